// File: spvp_fifo.sv
package spvp_pkg;
  // Serial framing
  localparam int CODE_W = 4;
  localparam int INSTR_W = 24;
  localparam int VIS_W = 16;
  localparam int BYTE_W = 8;
  localparam int EXEC_W = 16;
  localparam int EXEC_DEPTH = 16;
  localparam logic [3:0] CODE_INJECT = 4'h0;
  localparam logic [3:0] CODE_REG_OUT = 4'h1;
  localparam logic [3:0] REG_OUT_GAP = 4'h8;
  // Addresses
  localparam logic [23:0] APP_ID_ADDR = 24'h8005BE;
  localparam logic [23:0] EXEC_BASE = 24'h800000;
  localparam logic [15:0] VISI_ADDR = 16'h0784;
  // Arbitrary identifier value, not tied to any real executive
  localparam logic [15:0] APP_ID_DEFAULT = 16'h005A;
  // Injected instruction decoding
  localparam logic [3:0] OP_MOV_LIT = 4'h2;
  localparam logic [7:0] OP_TABLE_READ_LOW = 8'hBA;
  localparam logic [23:0] INSTR_MOV_TABLE_PAGE = 24'h880190;
  localparam logic [2:0] MODE_POSTINC = 3'h3;
  localparam logic [15:0] PTR_STEP = 16'h0002;
  // Executive command opcodes, upper nibble of a command word
  typedef enum logic [3:0] {
    CMD_SANITY_CHECK = 4'h0,
    CMD_READ_DEVICE_ID = 4'h1,
    CMD_READ_EEPROM = 4'h2,
    CMD_READ_CODE = 4'h3,
    CMD_WRITE_USER_ID = 4'h4,
    CMD_PROGRAM_EEPROM_WORD = 4'h5,
    CMD_PROGRAM_CODE_ROW = 4'h6,
    CMD_BLANK_QUERY = 4'h7,
    CMD_VERSION_QUERY = 4'h8
  } spvp_cmd_t;
  localparam logic [3:0] CMD_LAST = 4'h8;
  // Port states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_CODE = 6'b000010,
    ST_INSTR = 6'b000100,
    ST_GAP = 6'b001000,
    ST_OUT = 6'b010000,
    ST_EXEC = 6'b100000
  } spvp_state_t;
endpackage

module spvp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= AW'((wr_ptr_r + 1'b1) % DEPTH);
      end
      if (pop) begin
        rd_ptr_r <= AW'((rd_ptr_r + 1'b1) % DEPTH);
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// File: spvp_port.sv
// Operation
// RULE_01 - Read-back leaves the device a byte at a time, low byte first, so two bytes form one word.
// RULE_02 - The programmer verifies code right after writing it when protection is being enabled.
// RULE_03 - With code-protect bits at 0 after a reset, read-back of protected memory returns nothing.
// RULE_04 - The application identifier word sits at 8005BEh in executive memory.
// RULE_05 - Injected instructions copy a location into the visibility register, register-out shifts it out.
// RULE_06 - The programmer checks the identifier before command-based programming.
// RULE_07 - Withdrawing the high level from the reset/programming pin leaves program mode.
// RULE_08 - The programmer waits the exit hold interval after the last clock or data edge.
// RULE_09 - The identifier sequence loads table page 0x80, pointer 0x5BE and the visibility pointer.
// RULE_10 - Code 0001 shifts the visibility register out, code 0000 injects the next 24-bit instruction.
// RULE_11 - Entering enhanced mode starts the resident executive.
// RULE_12 - The executive takes the nine listed command kinds.
// RULE_13 - The programmer treats data RAM as undefined after the executive ran.
// RULE_14 - The programmer follows the fixed erase, check, program and verify order.
// RULE_15 - The visibility register answers at data address 784h.
module spvp_port #(
  parameter logic [15:0] APP_ID = spvp_pkg::APP_ID_DEFAULT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Programming pins
  input wire logic reset_progvoltage_pin,
  input wire logic prog_clock_line,
  input wire logic prog_data_line_in,
  output logic prog_data_line_out,
  output logic prog_data_line_oe,
  // Mode and configuration
  input wire logic enhanced_mode,
  input wire logic [1:0] code_protect_bits,
  // Memory read port, data valid the cycle after the strobe
  output logic mem_rd_r,
  output logic [23:0] mem_addr_r,
  input wire logic [15:0] mem_rdata,
  // Executive side
  output logic exec_run_r,
  output logic exec_word_valid,
  output logic [15:0] exec_word,
  input wire logic exec_word_ready,
  output logic [3:0] exec_cmd_r,
  output logic exec_cmd_known_r
);
  // Pin synchronisers
  logic [1:0] vpp_sync_r;
  logic [2:0] clk_sync_r;
  logic [1:0] dat_sync_r;
  wire prog_mode = vpp_sync_r[1];
  wire clk_rise = clk_sync_r[1] && !clk_sync_r[2];
  wire dat_bit = dat_sync_r[1];

  spvp_pkg::spvp_state_t state_r, state_nxt;
  logic [23:0] shift_r;
  logic [4:0] bit_cnt_r;
  logic [15:0] vis_r;
  logic [15:0] out_sh_r;
  logic [15:0] w_r [16];
  logic [7:0] table_page_r;
  logic protect_r;
  logic cp_caught_r;
  logic [1:0] rd_pend_r;
  logic rd_app_r;
  logic rd_vis_r;
  logic rd_block_r;
  logic word_pend_r;
  logic [15:0] word_r;

  // Injected instruction decoding
  wire [23:0] instr = {dat_bit, shift_r[23:1]};
  wire is_mov_lit = (instr[23:20] == spvp_pkg::OP_MOV_LIT);
  wire is_mov_table_page = (instr == spvp_pkg::INSTR_MOV_TABLE_PAGE);
  wire is_table_read_low = (instr[23:16] == spvp_pkg::OP_TABLE_READ_LOW);
  wire [3:0] src_w = instr[3:0];
  wire [3:0] dst_w = instr[10:7];
  wire src_postinc = (instr[6:4] == spvp_pkg::MODE_POSTINC);
  wire [23:0] rd_addr = {table_page_r, w_r[src_w]};
  wire rd_is_app = (rd_addr == spvp_pkg::APP_ID_ADDR);
  wire rd_is_user = (rd_addr < spvp_pkg::EXEC_BASE);
  wire dst_is_vis = (w_r[dst_w] == spvp_pkg::VISI_ADDR);

  wire code_done = clk_rise && state_r == spvp_pkg::ST_CODE &&
                   bit_cnt_r == 5'(spvp_pkg::CODE_W - 1);
  wire instr_done = clk_rise && state_r == spvp_pkg::ST_INSTR &&
                    bit_cnt_r == 5'(spvp_pkg::INSTR_W - 1);
  wire gap_done = clk_rise && state_r == spvp_pkg::ST_GAP &&
                  bit_cnt_r == 5'(spvp_pkg::REG_OUT_GAP - 1);
  wire out_done = clk_rise && state_r == spvp_pkg::ST_OUT &&
                  bit_cnt_r == 5'(spvp_pkg::VIS_W - 1);
  wire exec_word_done = clk_rise && state_r == spvp_pkg::ST_EXEC &&
                        !word_pend_r &&
                        bit_cnt_r == 5'(spvp_pkg::EXEC_W - 1);
  wire [3:0] code_in = {dat_bit, shift_r[23:21]};
  wire word_ready;
  wire [15:0] rd_data = rd_app_r ? APP_ID :
                        (rd_block_r ? 16'h0000 : mem_rdata);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spvp_pkg::ST_IDLE: begin
        if (prog_mode) begin
          state_nxt = enhanced_mode ? spvp_pkg::ST_EXEC
                                    : spvp_pkg::ST_CODE; // [RULE_11]
        end
      end
      spvp_pkg::ST_CODE: begin
        if (code_done) begin
          state_nxt = (code_in == spvp_pkg::CODE_REG_OUT) ?
                      spvp_pkg::ST_GAP : spvp_pkg::ST_INSTR; // [RULE_10]
        end
      end
      spvp_pkg::ST_INSTR: begin
        if (instr_done) begin
          state_nxt = spvp_pkg::ST_CODE;
        end
      end
      spvp_pkg::ST_GAP: begin
        if (gap_done) begin
          state_nxt = spvp_pkg::ST_OUT;
        end
      end
      spvp_pkg::ST_OUT: begin
        if (out_done) begin
          state_nxt = spvp_pkg::ST_CODE;
        end
      end
      spvp_pkg::ST_EXEC: state_nxt = spvp_pkg::ST_EXEC;
      default: state_nxt = spvp_pkg::ST_IDLE;
    endcase
    if (!prog_mode) begin
      state_nxt = spvp_pkg::ST_IDLE; // [RULE_07]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vpp_sync_r <= '0;
      clk_sync_r <= '0;
      dat_sync_r <= '0;
    end else begin
      vpp_sync_r <= {vpp_sync_r[0], reset_progvoltage_pin};
      clk_sync_r <= {clk_sync_r[1:0], prog_clock_line};
      dat_sync_r <= {dat_sync_r[0], prog_data_line_in};
    end
  end

  // Protection is caught once, in the first cycle after reset release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      protect_r <= 1'b0;
      cp_caught_r <= 1'b0;
    end else if (!cp_caught_r) begin
      protect_r <= (code_protect_bits != 2'h3); // [RULE_03]
      cp_caught_r <= 1'b1;
    end
  end

  // Serial shifting, LSB first, sampled on the rising clock edge
  always_ff @(posedge clock) begin
    if (!rst_n || state_nxt != state_r) begin
      bit_cnt_r <= '0;
    end else if (clk_rise && !(state_r == spvp_pkg::ST_EXEC &&
                              word_pend_r)) begin
      bit_cnt_r <= exec_word_done ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (clk_rise) begin
      shift_r <= {dat_bit, shift_r[23:1]};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= spvp_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Injected instruction execution
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      table_page_r <= '0;
      for (int i = 0; i < 16; i++) begin
        w_r[i] <= '0;
      end
    end else if (instr_done) begin
      if (is_mov_lit) begin
        w_r[instr[3:0]] <= instr[19:4]; // [RULE_09]
      end else if (is_mov_table_page) begin
        table_page_r <= w_r[0][7:0]; // [RULE_09]
      end else if (is_table_read_low && src_postinc) begin
        w_r[src_w] <= w_r[src_w] + spvp_pkg::PTR_STEP;
      end
    end
  end

  // Table read: identifier is internal, protected user reads give zero, the rest goes to memory
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_rd_r <= 1'b0;
      mem_addr_r <= '0;
      rd_pend_r <= '0;
      rd_app_r <= 1'b0;
      rd_vis_r <= 1'b0;
      rd_block_r <= 1'b0;
    end else begin
      mem_rd_r <= instr_done && is_table_read_low && !rd_is_app &&
                  !(protect_r && rd_is_user);
      rd_pend_r <= {rd_pend_r[0], instr_done && is_table_read_low};
      if (instr_done && is_table_read_low) begin
        mem_addr_r <= rd_addr;
        rd_app_r <= rd_is_app; // [RULE_04]
        rd_vis_r <= dst_is_vis; // [RULE_15]
        rd_block_r <= protect_r && rd_is_user; // [RULE_03]
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      vis_r <= '0;
    end else if (rd_pend_r[1] && rd_vis_r) begin
      vis_r <= rd_data; // [RULE_05]
    end
  end

  // Register-out: low byte then high byte, changed on rising edges
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      out_sh_r <= '0;
      prog_data_line_out <= 1'b0;
      prog_data_line_oe <= 1'b0;
    end else if (gap_done) begin
      out_sh_r <= {1'b0, vis_r[15:1]}; // [RULE_01]
      prog_data_line_out <= vis_r[0];
      prog_data_line_oe <= 1'b1; // [RULE_10]
    end else if (out_done || state_r != spvp_pkg::ST_OUT) begin
      prog_data_line_oe <= 1'b0;
      prog_data_line_out <= 1'b0;
    end else if (clk_rise) begin
      out_sh_r <= {1'b0, out_sh_r[15:1]};
      prog_data_line_out <= out_sh_r[0];
    end
  end

  // Enhanced mode: incoming words queue for the executive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      exec_run_r <= 1'b0;
      word_pend_r <= 1'b0;
      word_r <= '0;
    end else begin
      exec_run_r <= (state_r == spvp_pkg::ST_EXEC); // [RULE_11]
      if (exec_word_done) begin
        word_pend_r <= 1'b1;
        word_r <= {dat_bit, shift_r[23:9]};
      end else if (word_ready || state_r != spvp_pkg::ST_EXEC) begin
        word_pend_r <= 1'b0;
      end
    end
  end

  spvp_fifo #(
    .WIDTH(spvp_pkg::EXEC_W),
    .DEPTH(spvp_pkg::EXEC_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(word_pend_r),
    .in_data(word_r),
    .in_ready(word_ready),
    .out_valid(exec_word_valid),
    .out_data(exec_word),
    .out_ready(exec_word_ready)
  );

  // Opcode of the word taken last by the executive
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      exec_cmd_r <= '0;
      exec_cmd_known_r <= 1'b0;
    end else if (exec_word_valid && exec_word_ready) begin
      exec_cmd_r <= exec_word[15:12];
      exec_cmd_known_r <= (exec_word[15:12] <= spvp_pkg::CMD_LAST); // [RULE_12]
    end
  end
endmodule

// File: spvp_port_checker.sv
module spvp_port_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Watched ports
  input wire logic reset_progvoltage_pin,
  input wire logic enhanced_mode,
  input wire logic prog_data_line_oe,
  input wire logic mem_rd_r,
  input wire logic exec_run_r,
  input wire logic exec_word_valid,
  input wire logic [15:0] exec_word,
  input wire logic exec_word_ready,
  input wire logic [3:0] exec_cmd_r,
  input wire logic exec_cmd_known_r
);
  wire logic [3:0] head_op = exec_word[15:12];
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_pin_gone;
    !reset_progvoltage_pin [*6];
  endsequence
  sequence s_pop;
    exec_word_valid && exec_word_ready;
  endsequence
  a_pin_exit: assert property (
    s_pin_gone |-> !prog_data_line_oe && !exec_run_r)
    else $error("port active without programming level");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !prog_data_line_oe && !mem_rd_r && !exec_run_r)
    else $error("outputs active after reset");
  a_strobe_pulse: assert property (mem_rd_r |=> !mem_rd_r)
    else $error("read strobe longer than one cycle");
  a_rd_low_mode: assert property (mem_rd_r |-> !exec_run_r)
    else $error("memory read while executive runs");
  a_oe_stands: assert property (
    $rose(prog_data_line_oe) |-> prog_data_line_oe [*8])
    else $error("data drive dropped within a bit");
  a_oe_low_mode: assert property (
    prog_data_line_oe |-> !exec_run_r)
    else $error("data driven in executive mode");
  a_exec_entry: assert property (
    $rose(exec_run_r) |-> enhanced_mode)
    else $error("executive started outside enhanced mode");
  a_cmd_decode: assert property (
    s_pop |=> exec_cmd_r == $past(head_op) &&
      exec_cmd_known_r == ($past(head_op) <= spvp_pkg::CMD_LAST))
    else $error("command opcode not decoded");
  a_head_holds: assert property (
    exec_word_valid && !exec_word_ready |=>
      exec_word_valid && $stable(exec_word))
    else $error("queue head lost while stalled");
endmodule

bind spvp_port spvp_port_checker spvp_port_checker_inst (.clock, .rst_n,
  .reset_progvoltage_pin, .enhanced_mode, .prog_data_line_oe, .mem_rd_r,
  .exec_run_r, .exec_word_valid, .exec_word, .exec_word_ready, .exec_cmd_r,
  .exec_cmd_known_r);

// File: spvp_programmer.sv
module spvp_programmer #(
  parameter int HOLD_NS = 400
) (
  // Pins toward the device
  output logic reset_progvoltage_pin,
  output logic prog_clock_line,
  output logic prog_data_line_drv,
  input wire logic prog_data_line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reset_progvoltage_pin = 1'b0;
    prog_clock_line = 1'b0;
    prog_data_line_drv = 1'b0;
  end
  // One link clock; a released line shows the inverse of its last level
  task automatic clk_bit(input logic d, input logic drv, output logic q);
    prog_data_line_drv = drv ? d : ~prog_data_line_drv;
    #80 prog_clock_line = 1'b1;
    #160 prog_clock_line = 1'b0;
    #80 q = prog_data_line_in;
  endtask
  task automatic shift(input logic [23:0] v, input int n);
    logic q;
    for (int i = 0; i < n; i++) clk_bit(v[i], 1'b1, q);
  endtask
  task automatic inject(input logic [23:0] ins);
    shift({20'h00000, spvp_pkg::CODE_INJECT}, 4);
    shift(ins, 24);
  endtask
  task automatic word(input logic [15:0] v);
    shift({8'h00, v}, 16);
  endtask
  // Low byte then high byte form the word
  task automatic read_out(output logic [15:0] v);
    logic q;
    shift({20'h00000, spvp_pkg::CODE_REG_OUT}, 4);
    for (int i = 0; i < 7; i++) clk_bit(1'b0, 1'b0, q);
    for (int i = 0; i < 16; i++) begin
      clk_bit(1'b0, 1'b0, q);
      v[i] = q;
    end
    clk_bit(1'b0, 1'b0, q);
  endtask
  task automatic enter();
    #13 reset_progvoltage_pin = 1'b1;
    #400;
  endtask
  // Wait the exit hold interval after the last edge
  task automatic leave();
    #HOLD_NS reset_progvoltage_pin = 1'b0;
    #400;
  endtask
endmodule

// File: spvp_port_test.sv
module spvp_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Arbitrary identifier value
  localparam logic [15:0] ID = 16'h61C3;
  localparam logic [15:0] VIS = spvp_pkg::VISI_ADDR;
  logic clock = 1'b0, rst_n = 1'b0, enhanced_mode = 1'b0;
  logic exec_word_ready = 1'b0;
  logic [1:0] code_protect_bits = 2'h3;
  logic [15:0] mem_rdata = 16'h0000;
  logic reset_progvoltage_pin, prog_clock_line, prog_data_line_drv;
  logic prog_data_line_in, prog_data_line_out, prog_data_line_oe, mem_rd_r;
  logic exec_run_r, exec_word_valid, exec_cmd_known_r;
  logic [23:0] mem_addr_r;
  logic [15:0] exec_word, v;
  logic [3:0] exec_cmd_r;
  int mismatches = 0, checks = 0;
  always #20 clock = ~clock;
  assign prog_data_line_in = prog_data_line_oe ? prog_data_line_out
                                               : prog_data_line_drv;
  // Memory answers only in the cycle after the strobe
  always @(posedge clock)
    mem_rdata <= mem_rd_r ? mem_addr_r[15:0] ^ 16'hA5C3 : ~mem_rdata;
  spvp_port #(.APP_ID(ID)) spvp_port_inst (.clock, .rst_n,
    .reset_progvoltage_pin, .prog_clock_line, .prog_data_line_in,
    .prog_data_line_out, .prog_data_line_oe, .enhanced_mode,
    .code_protect_bits, .mem_rd_r, .mem_addr_r, .mem_rdata, .exec_run_r,
    .exec_word_valid, .exec_word, .exec_word_ready, .exec_cmd_r,
    .exec_cmd_known_r);
  spvp_programmer spvp_programmer_inst (.reset_progvoltage_pin,
    .prog_clock_line, .prog_data_line_drv, .prog_data_line_in);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd_word(input logic [15:0] pg, ptr, dst);
    logic [23:0] s [11];
    s = '{24'h0, 24'h040200, 24'h0, {4'h2, pg, 4'h0}, 24'h880190,
      {4'h2, ptr, 4'h0}, {4'h2, dst, 4'h1}, 24'h0, 24'hBA0890, 24'h0, 24'h0};
    foreach (s[i]) spvp_programmer_inst.inject(s[i]);
    spvp_programmer_inst.read_out(v);
    spvp_programmer_inst.inject(24'h0);
  endtask
  function automatic logic [15:0] w(int i);
    return {4'(i % 10), 12'(i * 37)};
  endfunction
  task automatic t_app_id();
    spvp_programmer_inst.enter();
    spvp_programmer_inst.shift(24'hFFFFFF, 10);
    spvp_programmer_inst.leave();
    spvp_programmer_inst.enter();
    rd_word(16'h0080, 16'h05BE, VIS);
    check({8'h00, v[7:0]}, {8'h00, ID[7:0]});
    check({8'h00, v[15:8]}, {8'h00, ID[15:8]});
    $display("identifier test done");
  endtask
  task automatic t_code_read(input logic [15:0] exp);
    rd_word(16'h0000, 16'h1234, VIS);
    check(v, exp);
    rd_word(16'h0000, 16'h0F00, 16'h0700);
    check(v, exp);
    rd_word(16'h0080, 16'h05BE, VIS);
    check(v, ID);
    spvp_programmer_inst.leave();
    $display("code read test done");
  endtask
  task automatic t_exec();
    @(posedge clock);
    enhanced_mode <= 1'b1;
    spvp_programmer_inst.enter();
    for (int i = 0; i < 17; i++) spvp_programmer_inst.word(w(i));
    check(16'(exec_run_r), 16'h0001);
    for (int i = 0; i < 17; i++) begin
      for (int k = 0; k < 50 && exec_word_valid !== 1'b1; k++)
        @(posedge clock);
      check(exec_word, w(i));
      exec_word_ready <= 1'b1;
      @(posedge clock);
      exec_word_ready <= 1'b0;
      @(posedge clock);
      check({11'h000, exec_cmd_known_r, exec_cmd_r},
        {11'h000, 1'(i % 10 < 9), 4'(i % 10)});
    end
    check(16'(exec_word_valid), 16'h0000);
    spvp_programmer_inst.leave();
    check(16'(exec_run_r), 16'h0000);
    $display("executive test done");
  endtask
  initial begin
    #3000000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_app_id();
    t_code_read(16'h1234 ^ 16'hA5C3);
    @(posedge clock);
    rst_n <= 1'b0;
    code_protect_bits <= 2'h2;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    spvp_programmer_inst.enter();
    t_code_read(16'h0000);
    t_exec();
    finish_test();
  end
endmodule
